// ==== hw/tds_cfg.svh ====
// Timing, threshold and reset constants of the touch detect sequencer.
`ifndef TDS_CFG_SVH
`define TDS_CFG_SVH

`define TDS_CLK_PS          4000
`define TDS_FAST_GAP_US     1000
`define TDS_SLEEP_MS        80
`define TDS_BEAT_US         15
`define TDS_PULSE_MIN_US    10
`define TDS_FAST_GAP_CYC    ((`TDS_FAST_GAP_US * 1000000) / `TDS_CLK_PS)
`define TDS_SLEEP_CYC       ((`TDS_SLEEP_MS * 1000000) / (`TDS_CLK_PS / 1000))
`define TDS_BEAT_CYC        ((`TDS_BEAT_US * 1000000 + `TDS_CLK_PS - 1) / `TDS_CLK_PS)
`define TDS_PULSE_MIN_CYC   ((`TDS_PULSE_MIN_US * 1000000 + `TDS_CLK_PS - 1) / `TDS_CLK_PS)
`define TDS_THRESHOLD       10
`define TDS_HYSTERESIS      2
`define TDS_CONFIRM_COUNT   4
`define TDS_RECAL_BURSTS    255
`define TDS_DRIFT_UP_BURSTS 64
`define TDS_DRIFT_DN_BURSTS 4
`define TDS_REF_RESET       12'h000

`endif

// ==== hw/tds_drift.sv ====
// Slew-limited, asymmetric reference tracker for the burst signal.
`timescale 1ns/1ps
`default_nettype none
`include "tds_cfg.svh"

module tds_drift
  import tds_pkg::*;
#(
  parameter int         CW       = 12,
  parameter logic [7:0] UP_BURST = 8'(`TDS_DRIFT_UP_BURSTS),
  parameter logic [7:0] DN_BURST = 8'(`TDS_DRIFT_DN_BURSTS)
) (
  input  wire logic          i_clk,    // System clock.
  input  wire logic          i_rst_n,  // Asynchronous reset, active low.
  input  wire logic          i_step,   // One burst result is being evaluated.
  input  wire logic [CW-1:0] i_count,  // Raw burst count.
  input  wire logic          i_load,   // Copy the raw count into the reference.
  input  wire logic          i_freeze, // A detection is in effect.
  output logic      [CW-1:0] o_ref     // Current reference level.
);

  logic [CW-1:0] ref_ff;
  logic [CW-1:0] nxt_ref;
  logic [7:0]    up_cnt_ff;
  logic [7:0]    nxt_up_cnt;
  logic [7:0]    dn_cnt_ff;
  logic [7:0]    nxt_dn_cnt;

  always_comb begin
    nxt_ref    = ref_ff;
    nxt_up_cnt = up_cnt_ff;
    nxt_dn_cnt = dn_cnt_ff;
    if (i_load) begin
      nxt_ref    = i_count;
      nxt_up_cnt = 8'h00;
      nxt_dn_cnt = 8'h00;
    end else if (i_step) begin
      // R16: frozen tracking
      if (i_freeze || i_count == ref_ff) begin
        nxt_up_cnt = 8'h00;
        nxt_dn_cnt = 8'h00;
      // R18: fast downward follow
      end else if (i_count < ref_ff) begin
        nxt_up_cnt = 8'h00;
        nxt_dn_cnt = tds_sat_inc8(dn_cnt_ff);
        if (nxt_dn_cnt >= DN_BURST) begin
          nxt_ref    = ref_ff - CW'(1);
          nxt_dn_cnt = 8'h00;
        end
      // R18: slow upward follow
      end else begin
        nxt_dn_cnt = 8'h00;
        nxt_up_cnt = tds_sat_inc8(up_cnt_ff);
        if (nxt_up_cnt >= UP_BURST) begin
          nxt_ref    = ref_ff + CW'(1);
          nxt_up_cnt = 8'h00;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_ff    <= CW'(`TDS_REF_RESET);
      up_cnt_ff <= 8'h00;
      dn_cnt_ff <= 8'h00;
    end else begin
      ref_ff    <= nxt_ref;
      up_cnt_ff <= nxt_up_cnt;
      dn_cnt_ff <= nxt_dn_cnt;
    end
  end

  assign o_ref = ref_ff;

endmodule : tds_drift

`default_nettype wire

// ==== hw/tds_pkg.sv ====
// Types and helper functions of the touch detect sequencer.
package tds_pkg;

  typedef enum logic [1:0] {
    MODE_FAST       = 2'b00,
    SLOW_SLEEP_MODE = 2'b01,
    MODE_SYNC       = 2'b10
  } tds_mode_t;

  typedef enum logic [1:0] {
    ST_WAIT  = 2'b00,
    ST_BEAT  = 2'b01,
    ST_BURST = 2'b10
  } tds_state_t;

  typedef struct packed {
    logic        done;
    logic [11:0] count;
  } tds_result_t;

  function automatic logic [7:0] tds_sat_inc8(input logic [7:0] v);
    tds_sat_inc8 = (v == 8'hff) ? v : v + 8'h01;
  endfunction : tds_sat_inc8

  function automatic logic [24:0] tds_sat_inc25(input logic [24:0] v);
    tds_sat_inc25 = (v == 25'h1ffffff) ? v : v + 25'h0000001;
  endfunction : tds_sat_inc25

endpackage : tds_pkg

// ==== hw/tds_top.sv ====
// Burst scheduler, run-mode control and touch decision of the touch detect sequencer.
//
// Overview of operation
// R1: Four successive detecting bursts activate the output; any miss clears the count.
// R2: Pin held high gives fast mode, about one millisecond between bursts.
// R3: Pin held low gives low-power mode, eighty millisecond sleep after bursts.
// R4: A pending touch in low-power mode bursts fast until resolved.
// R5: Pin sampled at burst end; from fast, low enters sleep and sync mode.
// R6: Host holds the pin low longer than one burst to enter sync mode.
// R7: Sync mode sleeps after bursts and bursts on every pin edge.
// R8: Short pulses over ten microseconds in sync mode burst on falling edges only.
// R9: Pin quiet past eighty milliseconds in sync mode resumes fast or low-power.
// R10: Sync mode bypasses the confirmation count; one detection drives the output.
// R11: Recalibration timeout counts bursts, so it scales with burst rate.
// R12: Detection when signal exceeds reference by ten counts.
// R13: Active detection drops only when delta falls two counts lower.
// R14: A persistent detection never causes recalibration.
// R15: Reference calibrates only at power-up or recalibration timeout.
// R16: Reference tracks signal in slew-limited steps, frozen while detecting.
// R17: Threshold and hysteresis are relative to the current reference.
// R18: Reference follows falling signal faster than rising signal.
// R19: Output is high while a confirmed detection lasts.
// R20: Output released to high impedance for fifteen microseconds before each burst.
// R21: Each burst count arrives with a done strobe and is evaluated once.
// R22: One oscillator counter times gaps, sleeps and sync timeouts.
`timescale 1ns/1ps
`default_nettype none
`include "tds_cfg.svh"

module tds_top
  import tds_pkg::*;
#(
  parameter int          CW          = 12,
  parameter logic [24:0] FAST_GAP    = 25'(`TDS_FAST_GAP_CYC),
  parameter logic [24:0] SLEEP_GAP   = 25'(`TDS_SLEEP_CYC),
  parameter logic [24:0] PULSE_MAX   = 25'(`TDS_FAST_GAP_CYC),
  parameter logic [7:0]  RECAL_BURST = 8'(`TDS_RECAL_BURSTS)
) (
  input  wire logic        i_clk,         // System clock, 250 MHz.
  input  wire logic        i_rst_n,       // Asynchronous power-up reset, active low.
  input  wire logic        i_mode_sync,   // Mode and sync pin level.
  input  wire tds_result_t i_result,      // Burst done strobe with burst count.
  output logic             o_burst_start, // One-cycle request to start a burst.
  output logic             o_touch,       // Detect output level.
  output logic             o_touch_oe,    // Detect output driven when high.
  output logic [1:0]       o_mode         // Current run mode.
);

  localparam logic [24:0] BEAT_LEN  = 25'(`TDS_BEAT_CYC);
  localparam logic [24:0] PULSE_MIN = 25'(`TDS_PULSE_MIN_CYC);

  tds_state_t    state_ff, nxt_state;
  tds_mode_t     mode_ff, nxt_mode;
  logic [24:0]   timer_ff, nxt_timer;
  logic          start_ff, nxt_start;
  logic          oe_ff, nxt_oe;
  logic          pin_q_ff;
  logic [24:0]   high_cnt_ff, nxt_high_cnt;
  logic          pulse_mode_ff, nxt_pulse_mode;
  logic          pend_ff, nxt_pend;

  logic          active_ff, nxt_active;
  logic [2:0]    confirm_ff, nxt_confirm;
  logic [7:0]    recal_cnt_ff, nxt_recal_cnt;
  logic          cal_done_ff, nxt_cal_done;
  logic [CW-1:0] ref_lvl;
  logic          drift_load;
  logic          drift_freeze;

  logic          rise;
  logic          fall;
  logic          trig;
  logic          resolving;
  logic          step;
  logic signed [CW:0] delta;
  logic          above_on;
  logic          above_hold;
  logic          below_low;

  assign rise      = i_mode_sync & ~pin_q_ff;
  assign fall      = ~i_mode_sync & pin_q_ff;
  // R8: falling edge only in pulse mode
  assign trig      = (mode_ff == MODE_SYNC) && (fall || (rise && !pulse_mode_ff));
  assign resolving = (confirm_ff != 3'd0) && !active_ff;
  // R21: one evaluation per strobe
  assign step      = i_result.done && (state_ff == ST_BURST);
  // R17: delta taken against the live reference
  assign delta      = $signed({1'b0, i_result.count}) - $signed({1'b0, ref_lvl});
  // R12: fixed threshold
  assign above_on   = delta >= $signed((CW+1)'(`TDS_THRESHOLD));
  // R13: hysteresis on release
  assign above_hold = delta >= $signed((CW+1)'(`TDS_THRESHOLD - `TDS_HYSTERESIS));
  assign below_low  = delta <= -$signed((CW+1)'(`TDS_THRESHOLD));

  // Sync edge classification and pending trigger.
  always_comb begin
    nxt_high_cnt   = i_mode_sync ? tds_sat_inc25(high_cnt_ff) : 25'h0000000;
    nxt_pulse_mode = pulse_mode_ff;
    if (rise) begin
      nxt_high_cnt = 25'h0000000;
    end
    if (mode_ff != MODE_SYNC) begin
      nxt_pulse_mode = 1'b0;
    // R8: short pulse detection
    end else if (fall && high_cnt_ff >= PULSE_MIN && high_cnt_ff < PULSE_MAX) begin
      nxt_pulse_mode = 1'b1;
    end else if (fall && high_cnt_ff >= PULSE_MAX) begin
      nxt_pulse_mode = 1'b0;
    end
    // A trigger arriving during a beat or burst (outside ST_WAIT) is kept, not lost.
    nxt_pend = (pend_ff && !(state_ff == ST_WAIT && nxt_state == ST_BEAT)) || (trig && state_ff != ST_WAIT);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_q_ff      <= 1'b0;
      high_cnt_ff   <= 25'h0000000;
      pulse_mode_ff <= 1'b0;
      pend_ff       <= 1'b0;
    end else begin
      pin_q_ff      <= i_mode_sync;
      high_cnt_ff   <= nxt_high_cnt;
      pulse_mode_ff <= nxt_pulse_mode;
      pend_ff       <= nxt_pend;
    end
  end

  // Burst scheduler.
  always_comb begin
    nxt_state = state_ff;
    nxt_mode  = mode_ff;
    // R22: shared oscillator counter
    nxt_timer = tds_sat_inc25(timer_ff);
    nxt_start = 1'b0;
    nxt_oe    = 1'b1;
    case (state_ff)
      ST_WAIT: begin
        case (mode_ff)
          MODE_FAST: begin
            // R2: fast burst gap
            if (timer_ff >= FAST_GAP) begin
              nxt_state = ST_BEAT;
            end
          end
          SLOW_SLEEP_MODE: begin
            // R4: fast bursts while resolving
            if (resolving && timer_ff >= FAST_GAP) begin
              nxt_state = ST_BEAT;
            // R3: long sleep
            end else if (timer_ff >= SLEEP_GAP) begin
              nxt_state = ST_BEAT;
            end
          end
          default: begin
            // R7: wake on pin edge
            if (trig || pend_ff) begin
              nxt_state = ST_BEAT;
            // R9: quiet pin resumes normal mode
            end else if (timer_ff >= SLEEP_GAP) begin
              nxt_state = ST_BEAT;
              nxt_mode  = i_mode_sync ? MODE_FAST : SLOW_SLEEP_MODE;
            end else if (rise || fall) begin
              nxt_timer = 25'h0000000;
            end
          end
        endcase
        if (nxt_state == ST_BEAT) begin
          nxt_timer = 25'h0000000;
          nxt_oe    = 1'b0;
        end
      end
      ST_BEAT: begin
        // R20: output released before burst
        nxt_oe = 1'b0;
        if (timer_ff >= BEAT_LEN - 25'h0000001) begin
          nxt_state = ST_BURST;
          nxt_start = 1'b1;
          nxt_oe    = 1'b1;
        end
      end
      default: begin
        if (step) begin
          nxt_state = ST_WAIT;
          nxt_timer = 25'h0000000;
          // R5: pin sampled at burst end
          if (mode_ff == MODE_FAST || mode_ff == SLOW_SLEEP_MODE) begin
            if (i_mode_sync) begin
              nxt_mode = MODE_FAST;
            end else if (mode_ff == MODE_FAST) begin
              nxt_mode = MODE_SYNC;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ST_WAIT;
      mode_ff  <= MODE_FAST;
      timer_ff <= 25'h0000000;
      start_ff <= 1'b0;
      oe_ff    <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      mode_ff  <= nxt_mode;
      timer_ff <= nxt_timer;
      start_ff <= nxt_start;
      oe_ff    <= nxt_oe;
    end
  end

  // Touch decision per burst.
  always_comb begin
    nxt_active    = active_ff;
    nxt_confirm   = confirm_ff;
    nxt_recal_cnt = recal_cnt_ff;
    nxt_cal_done  = cal_done_ff;
    drift_load    = 1'b0;
    if (step) begin
      if (!cal_done_ff) begin
        // R15: power-up calibration
        drift_load   = 1'b1;
        nxt_cal_done = 1'b1;
      end else if (active_ff) begin
        // R14: no timeout while detecting
        nxt_recal_cnt = 8'h00;
        if (!above_hold) begin
          nxt_active  = 1'b0;
          nxt_confirm = 3'd0;
        end
      end else if (above_on) begin
        nxt_recal_cnt = 8'h00;
        // R10: no confirmation in sync mode
        if (mode_ff == MODE_SYNC) begin
          nxt_active  = 1'b1;
          nxt_confirm = 3'd0;
        // R1: four-count confirmation
        end else if (confirm_ff == 3'(`TDS_CONFIRM_COUNT - 1)) begin
          nxt_active  = 1'b1;
          nxt_confirm = 3'd0;
        end else begin
          nxt_confirm = confirm_ff + 3'd1;
        end
      end else begin
        // R1: miss clears the count
        nxt_confirm = 3'd0;
        // R11: timeout counted in bursts
        if (below_low) begin
          nxt_recal_cnt = tds_sat_inc8(recal_cnt_ff);
          if (nxt_recal_cnt >= RECAL_BURST) begin
            drift_load    = 1'b1;
            nxt_recal_cnt = 8'h00;
          end
        end else begin
          nxt_recal_cnt = 8'h00;
        end
      end
    end
  end

  // R16: tracking stops while detecting
  assign drift_freeze = active_ff || above_on;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active_ff    <= 1'b0;
      confirm_ff   <= 3'd0;
      recal_cnt_ff <= 8'h00;
      cal_done_ff  <= 1'b0;
    end else begin
      active_ff    <= nxt_active;
      confirm_ff   <= nxt_confirm;
      recal_cnt_ff <= nxt_recal_cnt;
      cal_done_ff  <= nxt_cal_done;
    end
  end

  tds_drift #(
    .CW (CW)
  ) u_drift (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_step   (step && cal_done_ff),
    .i_count  (i_result.count),
    .i_load   (drift_load),
    .i_freeze (drift_freeze),
    .o_ref    (ref_lvl)
  );

  assign o_burst_start = start_ff;
  // R19: output follows confirmed detection
  assign o_touch       = active_ff;
  assign o_touch_oe    = oe_ff;
  assign o_mode        = mode_ff;

endmodule : tds_top

`default_nettype wire

// ==== tb/tb_touch_detect_sequencer.sv ====
// Self-checking bench of the touch detect sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_touch_detect_sequencer;
  import tds_pkg::*;
  localparam logic [24:0] FAST_GAP  = 25'h0000032;
  localparam logic [24:0] SLEEP_GAP = 25'h0000190;
  localparam int          BEAT      = 3750;
  localparam int          FAST_MAX  = BEAT + int'(FAST_GAP) + 4;
  localparam int          SLOW_MIN  = BEAT + int'(SLEEP_GAP) - 4;
  logic        clk       = 1'b0;
  logic        rst_n     = 1'b0;
  logic        mode_sync = 1'b1;
  logic [11:0] fe_count  = 12'h000;
  logic [7:0]  fe_delay  = 8'h01;
  tds_result_t result;
  logic        burst_start, touch, touch_oe;
  logic [1:0]  mode;
  int          err_total  = 0;
  int          n_compared = 0;
  int          gap;
  always #2 clk = ~clk;
  tds_top #(.FAST_GAP(FAST_GAP), .SLEEP_GAP(SLEEP_GAP), .PULSE_MAX(25'h0001000), .RECAL_BURST(8'h02)) i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_mode_sync(mode_sync), .i_result(result),
    .o_burst_start(burst_start), .o_touch(touch), .o_touch_oe(touch_oe), .o_mode(mode));
  tds_front_model i_fe (.i_clk(clk), .i_rst_n(rst_n), .i_start(burst_start), .i_count(fe_count),
    .i_delay(fe_delay), .o_result(result));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Runs one burst; gap counts the cycles until its request.
  task automatic burst(input logic [11:0] cnt, input logic [7:0] dly);
    int n;
    fe_count = cnt;
    fe_delay = dly;
    gap = 0;
    n = 0;
    while (burst_start !== 1'b1 && gap < 20000) begin
      @(posedge clk);
      #1;
      gap++;
    end
    while (result.done !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("burst handshake", gap < 20000 && n < 300, 1'b1);
    @(posedge clk);
    #1;
  endtask : burst

  task automatic t_reset();
    check("touch in reset", touch, 1'b0);
    check("oe in reset", touch_oe, 1'b1);
    check("mode in reset", mode, MODE_FAST);
    rst_n = 1'b1;
    $display("test reset done");
  endtask : t_reset

  task automatic t_fast();
    burst(12'h064, 8'h01);
    check("touch after load", touch, 1'b0);
    for (int i = 0; i < 3; i++) begin
      burst(12'h06e, 8'h1e);
      check("touch while counting", touch, 1'b0);
    end
    check("fast gap", gap >= BEAT && gap <= FAST_MAX, 1'b1);
    burst(12'h064, 8'h01);
    check("touch after miss", touch, 1'b0);
    for (int i = 0; i < 4; i++) begin
      burst(12'h06e, 8'h01);
      check("touch on fourth", touch, i == 3);
    end
    burst(12'h06c, 8'h01);
    check("touch held", touch, 1'b1);
    check("mode fast", mode, MODE_FAST);
    burst(12'h06b, 8'h01);
    check("touch dropped", touch, 1'b0);
    $display("test fast done");
  endtask : t_fast

  task automatic t_sync();
    int n;
    // pin held low across a whole burst.
    mode_sync = 1'b0;
    burst(12'h064, 8'h01);
    check("mode sync", mode, MODE_SYNC);
    n = 0;
    repeat (300) begin
      @(posedge clk);
      #1;
      if (burst_start !== 1'b0) n++;
    end
    check("sleep in sync", n, 0);
    mode_sync = 1'b1;
    burst(12'h06e, 8'h01);
    check("rise wakes", gap <= BEAT + 8, 1'b1);
    check("single detect", touch, 1'b1);
    mode_sync = 1'b0;
    burst(12'h064, 8'h1e);
    check("fall wakes", gap <= BEAT + 8, 1'b1);
    check("touch released", touch, 1'b0);
    // The high span that just ended was a short pulse, so a rise alone must not wake.
    mode_sync = 1'b1;
    n = 0;
    repeat (300) begin
      @(posedge clk);
      #1;
      if (burst_start !== 1'b0) n++;
    end
    check("rise ignored", n, 0);
    mode_sync = 1'b0;
    burst(12'h050, 8'h01);
    check("pulse fall wakes", gap <= BEAT + 8, 1'b1);
    burst(12'h050, 8'h01);
    check("quiet gap", gap >= SLOW_MIN, 1'b1);
    check("resume slow", mode, SLOW_SLEEP_MODE);
    $display("test sync done");
  endtask : t_sync

  task automatic t_slow();
    burst(12'h05a, 8'h01);
    check("slow sleep", gap >= SLOW_MIN, 1'b1);
    // Two far-low bursts reloaded the reference, so the count above was a detection.
    burst(12'h050, 8'h01);
    check("fast while pending", gap <= FAST_MAX, 1'b1);
    check("recal reload", gap <= FAST_MAX, 1'b1);
    mode_sync = 1'b1;
    burst(12'h050, 8'h01);
    check("back to slow", gap >= SLOW_MIN, 1'b1);
    check("high pin gives fast", mode, MODE_FAST);
    $display("test slow done");
  endtask : t_slow

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    $display("BAD watchdog expected finish seen timeout");
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clk);
    #1;
    t_reset();
    t_fast();
    t_sync();
    t_slow();
    give_verdict();
  end
endmodule : tb_touch_detect_sequencer
`default_nettype wire

// ==== tb/tds_front_model.sv ====
// Behavioural front end that answers each burst request with one count.
`timescale 1ns/1ps
`default_nettype none
module tds_front_model
  import tds_pkg::*;
(
  input  wire logic        i_clk,    // Clock.
  input  wire logic        i_rst_n,  // Reset, active low.
  input  wire logic        i_start,  // Burst request.
  input  wire logic [11:0] i_count,  // Count to report.
  input  wire logic [7:0]  i_delay,  // Cycles to answer in.
  output var  tds_result_t o_result  // Strobe with count.
);
  logic [7:0]  wait_ff, nxt_wait;
  logic        busy_ff, nxt_busy;
  tds_result_t nxt_result;
  // one strobe per burst; count lines toggle when not valid.
  always_comb begin
    nxt_wait   = wait_ff - 8'h01;
    nxt_busy   = busy_ff;
    nxt_result = '{done: 1'b0, count: ~o_result.count};
    if (i_start) begin
      nxt_busy = 1'b1;
      nxt_wait = i_delay;
    end else if (busy_ff && wait_ff <= 8'h01) begin
      nxt_busy   = 1'b0;
      nxt_result = '{done: 1'b1, count: i_count};
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_ff  <= 8'h00;
      busy_ff  <= 1'b0;
      o_result <= '0;
    end else begin
      wait_ff  <= nxt_wait;
      busy_ff  <= nxt_busy;
      o_result <= nxt_result;
    end
  end
endmodule : tds_front_model
`default_nettype wire

// ==== tb/tds_top_monitor.sv ====
// Port checker of the touch detect sequencer.
`timescale 1ns/1ps
`default_nettype none
module tds_top_monitor
  import tds_pkg::*;
#(
  parameter logic [24:0] FAST_GAP = 25'h003d090
) (
  input wire logic        i_clk,         // Clock.
  input wire logic        i_rst_n,       // Reset, active low.
  input wire logic        i_mode_sync,   // Mode pin.
  input wire tds_result_t i_result,      // Burst result.
  input wire logic        o_burst_start, // Burst request.
  input wire logic        o_touch,       // Detect level.
  input wire logic        o_touch_oe,    // Output enable.
  input wire logic [1:0]  o_mode         // Run mode.
);
  localparam int BEAT   = 3750;
  localparam int GAP_LO = int'(FAST_GAP) + BEAT - 4;
  localparam int GAP_HI = int'(FAST_GAP) + BEAT + 6;
  logic [15:0] beat_ff, nxt_beat;
  logic [31:0] gap_ff, nxt_gap;
  logic        burst_ff, nxt_burst, away_ff, nxt_away, take;
  assign take = burst_ff & i_result.done;
  // Away marks a wait that did not start in fast mode.
  always_comb begin
    nxt_beat  = o_touch_oe ? 16'h0000 : beat_ff + 16'h0001;
    nxt_gap   = take ? 32'h0000_0000 : gap_ff + 32'h0000_0001;
    nxt_burst = o_burst_start | (burst_ff & ~i_result.done);
    nxt_away  = ~take & (away_ff | (o_mode != MODE_FAST));
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      beat_ff  <= 16'h0000;
      gap_ff   <= 32'h0000_0000;
      burst_ff <= 1'b0;
      away_ff  <= 1'b0;
    end else begin
      beat_ff  <= nxt_beat;
      gap_ff   <= nxt_gap;
      burst_ff <= nxt_burst;
      away_ff  <= nxt_away;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_start_one_cycle: assert property (o_burst_start |=> !o_burst_start)
    else $error("burst request longer than one cycle");
  a_beat_length: assert property ($rose(o_touch_oe) |-> beat_ff == 16'(BEAT))
    else $error("released output span wrong");
  a_start_on_oe: assert property (o_burst_start == $rose(o_touch_oe))
    else $error("burst request not with output re-drive");
  a_touch_holds: assert property (!$past(i_result.done) |-> $stable(o_touch))
    else $error("detect output moved without a result");
  a_sync_entry: assert property (take && o_mode == MODE_FAST && !i_mode_sync |=> o_mode == MODE_SYNC)
    else $error("low pin at burst end did not enter sync");
  a_fast_stays: assert property (take && o_mode == MODE_FAST && i_mode_sync |=> o_mode == MODE_FAST)
    else $error("high pin left fast mode");
  a_slow_exit: assert property (take && o_mode == SLOW_SLEEP_MODE && i_mode_sync |=> o_mode == MODE_FAST)
    else $error("high pin at burst end kept slow mode");
  a_fast_gap: assert property (o_burst_start && !away_ff && o_mode == MODE_FAST |->
    gap_ff >= GAP_LO && gap_ff <= GAP_HI)
    else $error("fast burst spacing wrong");
  c_sync_touch: cover property (take && o_mode == MODE_SYNC ##1 $rose(o_touch));
  c_fast_touch: cover property (o_mode == MODE_FAST && $rose(o_touch));
  c_slow_burst: cover property (o_mode == SLOW_SLEEP_MODE && o_burst_start);
endmodule : tds_top_monitor
bind tds_top tds_top_monitor #(.FAST_GAP(FAST_GAP)) i_mon (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_mode_sync(i_mode_sync), .i_result(i_result),
  .o_burst_start(o_burst_start), .o_touch(o_touch), .o_touch_oe(o_touch_oe), .o_mode(o_mode));
`default_nettype wire
